// [design/fcs_params.svh]
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH

// device register offsets (byte addresses on the device port)
`define FCS_OFS_START      6'h04
`define FCS_OFS_STEP       6'h10
`define FCS_OFS_IVAL       6'h1A
`define FCS_OFS_MODE       6'h1E
`define FCS_OFS_CTRL       6'h1F
`define FCS_OFS_TIMER      6'h24
`define FCS_OFS_ACC_RD     6'h30

// byte counts of the multi-byte registers
`define FCS_START_BYTES    6
`define FCS_STEP_BYTES     6
`define FCS_IVAL_BYTES     3
`define FCS_TIMER_BYTES    4
`define FCS_ACC_BYTES      6

// control register fields
`define FCS_CTRL_AUTO_UPD  0
`define FCS_CTRL_RESTART   2
`define FCS_CTRL_ZERO      3

// mode field code for chirp
`define FCS_MODE_CHIRP     3'h3

// reset values
`define FCS_RST_BYTE       8'h00
`define FCS_RST_MODE       3'h0

// host command port offsets
`define FCS_H_ITEMS        21
`define FCS_H_OFS_CMD      5'h18
`define FCS_H_OFS_STAT     5'h19
`define FCS_H_CMD_GO       0
`define FCS_H_CMD_FREEZE   1

`endif

// [design/fcs_pkg.sv]
`default_nettype none

package fcs_pkg;
  typedef logic [47:0] fcs_word_type;
  typedef logic [7:0]  fcs_byte_type;
  typedef enum logic [1:0] {
    FCS_H_IDLE,
    FCS_H_SEND,
    FCS_H_COMMIT
  } fcs_host_state_type;
endpackage : fcs_pkg

`default_nettype wire

// [design/fcs_link_if.sv]
`default_nettype none

interface fcs_link_if;
  // register port, driven by the host
  logic [5:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  // read data, one cycle after rd
  logic [7:0] rdata;
  // update strobe and freeze pin
  logic       update;
  logic       freeze;

  modport dev (
    input  addr, wdata, wr, rd, update, freeze,
    output rdata
  );
  modport host (
    output addr, wdata, wr, rd, update, freeze,
    input  rdata
  );
endinterface : fcs_link_if

`default_nettype wire

// [design/fcs_step_counter.sv]
`default_nettype none

module fcs_step_counter #(
  parameter int unsigned W = 20
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] reload_i,
  output logic              step_o
);
  logic [W-1:0] cnt_q;

  // one pulse each time the count reaches zero while clocked
  assign step_o = en_i && (cnt_q == '0);

  // reload only happens at zero, so a new interval waits for the old countdown
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (en_i) begin
      if (cnt_q == '0) begin
        cnt_q <= reload_i;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : fcs_step_counter

`default_nettype wire

// [design/fcs_device.sv]
// Notes on behaviour
// - start word is the base of sweep
// - signed 48-bit step word held
// - 20-bit step interval count held
// - settings take effect on update strobe
// - step sign bit sets sweep direction
// - no limit at start frequency
// - restart bit gives one-cycle accumulator clear
// - restart leaves step word untouched
// - restart held: clear on each update edge
// - clear returns to start, sweep continues
// - zero bit clears both accumulators continuously
// - registers writable during zero output
// - freeze pin stops interval counter
// - freeze release resumes from held frequency
// - old countdown finishes before new interval
// - freeze honoured only in chirp mode
// - internal 32-bit timer makes update strobes
// - sweep wraps freely, never stops
// - zero step word holds frequency
// - interval counter pulses at zero
// - step period is interval plus one
// - start plus accumulator feeds phase accumulator
`include "fcs_params.svh"
`default_nettype none

module fcs_device
  import fcs_pkg::*;
#(
  parameter int unsigned IVAL_W  = 20,
  parameter int unsigned TIMER_W = 32
) (
  // clock and reset
  input  wire logic         SYS_CLK_I,
  input  wire logic         RST_I,
  // link to the host
  fcs_link_if.dev           LINK,
  // synthesizer outputs
  output fcs_word_type      TUNING_WORD_O,
  output fcs_word_type      PHASE_O,
  output logic              STEP_O,
  output logic              CHIRP_ACTIVE_O
);
  fcs_byte_type             buf_q [0:63];
  fcs_word_type             start_q;
  fcs_word_type             step_q;
  logic [IVAL_W-1:0]        ival_q;
  logic [TIMER_W-1:0]       timer_ld_q;
  logic [TIMER_W-1:0]       timer_q;
  logic [7:0]               ctrl_q;
  logic [2:0]               mode_q;
  logic                     upd_prev_q;
  logic                     clr_q;
  fcs_word_type             facc_q;
  fcs_word_type             pacc_q;
  fcs_word_type             tune_q;
  fcs_byte_type             rdata_q;
  fcs_word_type             buf_start;
  fcs_word_type             buf_step;
  logic [23:0]              buf_ival;
  logic [31:0]              buf_timer;
  logic                     auto_upd;
  logic                     upd;
  logic                     upd_rise;
  logic                     chirp;
  logic                     zero;
  logic                     cnt_en;
  logic                     step;
  fcs_word_type             tune_d;
  fcs_byte_type             rd_val;
  logic                     mapped;

  // lowest address holds the most significant byte
  assign buf_start = {buf_q[4], buf_q[5], buf_q[6], buf_q[7], buf_q[8], buf_q[9]};
  assign buf_step  = {buf_q[16], buf_q[17], buf_q[18], buf_q[19], buf_q[20], buf_q[21]};
  assign buf_ival  = {buf_q[26], buf_q[27], buf_q[28]};
  assign buf_timer = {buf_q[36], buf_q[37], buf_q[38], buf_q[39]};

  // address decode of the writable buffer bytes
  always_comb begin
    mapped = 1'b0;
    if (LINK.addr >= `FCS_OFS_START && LINK.addr < `FCS_OFS_START + 6'(`FCS_START_BYTES)) begin
      mapped = 1'b1;
    end
    if (LINK.addr >= `FCS_OFS_STEP && LINK.addr < `FCS_OFS_STEP + 6'(`FCS_STEP_BYTES)) begin
      mapped = 1'b1;
    end
    if (LINK.addr >= `FCS_OFS_IVAL && LINK.addr < `FCS_OFS_IVAL + 6'(`FCS_IVAL_BYTES)) begin
      mapped = 1'b1;
    end
    if (LINK.addr == `FCS_OFS_MODE || LINK.addr == `FCS_OFS_CTRL) begin
      mapped = 1'b1;
    end
    if (LINK.addr >= `FCS_OFS_TIMER && LINK.addr < `FCS_OFS_TIMER + 6'(`FCS_TIMER_BYTES)) begin
      mapped = 1'b1;
    end
  end

  // buffer bytes take writes at any time, also while output is zeroed
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < 64; i++) begin
        buf_q[i] <= `FCS_RST_BYTE;
      end
    end else if (LINK.wr && mapped) begin
      buf_q[LINK.addr] <= LINK.wdata;
    end
  end

  // internal update timer, counts only while enabled
  assign auto_upd = ctrl_q[`FCS_CTRL_AUTO_UPD] && (timer_q == '0);
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      timer_q <= '0;
    end else if (!ctrl_q[`FCS_CTRL_AUTO_UPD]) begin
      timer_q <= timer_ld_q;
    end else if (timer_q == '0) begin
      timer_q <= timer_ld_q;
    end else begin
      timer_q <= timer_q - 1'b1;
    end
  end

  // update strobe from the pin or the timer, acting on its rising edge
  assign upd      = LINK.update || auto_upd;
  assign upd_rise = upd && !upd_prev_q;
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      upd_prev_q <= 1'b0;
    end else begin
      upd_prev_q <= upd;
    end
  end

  // buffered settings become active only on update
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      start_q    <= '0;
      step_q     <= '0;
      ival_q     <= '0;
      timer_ld_q <= '0;
      ctrl_q     <= `FCS_RST_BYTE;
      mode_q     <= `FCS_RST_MODE;
    end else if (upd_rise) begin
      start_q    <= buf_start;
      step_q     <= buf_step;
      ival_q     <= buf_ival[IVAL_W-1:0];
      timer_ld_q <= buf_timer[TIMER_W-1:0];
      ctrl_q     <= buf_q[`FCS_OFS_CTRL];
      mode_q     <= buf_q[`FCS_OFS_MODE][2:0];
    end
  end

  // one-cycle clear on every update edge that finds the restart bit set
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      clr_q <= 1'b0;
    end else begin
      clr_q <= upd_rise && buf_q[`FCS_OFS_CTRL][`FCS_CTRL_RESTART];
    end
  end

  assign chirp = (mode_q == `FCS_MODE_CHIRP);
  assign zero  = ctrl_q[`FCS_CTRL_ZERO];
  // freeze gates the counter only in chirp mode
  assign cnt_en = chirp && !zero && !LINK.freeze;

  fcs_step_counter #(
    .W        (IVAL_W)
  ) u_step (
    .clk_i    (SYS_CLK_I),
    .rst_i    (RST_I),
    .en_i     (cnt_en),
    .reload_i (ival_q),
    .step_o   (step)
  );

  // frequency accumulator: signed step, plain 48-bit wrap, no limit
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      facc_q <= '0;
    end else if (!chirp || zero) begin
      facc_q <= '0;
    end else if (clr_q) begin
      facc_q <= '0;
    end else if (step) begin
      facc_q <= facc_q + step_q;
    end
  end

  // tuning word is start plus accumulated offset
  assign tune_d = zero ? '0 : start_q + (chirp ? facc_q : '0);
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tune_q <= '0;
      pacc_q <= '0;
    end else begin
      tune_q <= tune_d;
      pacc_q <= zero ? '0 : pacc_q + tune_q;
    end
  end

  // read data one cycle after the strobe; reads outside the buffer and the accumulator readback give zero
  always_comb begin
    rd_val = 8'h00;
    if (mapped) begin
      rd_val = buf_q[LINK.addr];
    end else if (LINK.addr >= `FCS_OFS_ACC_RD && LINK.addr < `FCS_OFS_ACC_RD + 6'(`FCS_ACC_BYTES)) begin
      rd_val = facc_q[8*(5 - (LINK.addr - `FCS_OFS_ACC_RD)) +: 8];
    end
  end
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_q <= 8'h00;
    end else if (LINK.rd) begin
      rdata_q <= rd_val;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign LINK.rdata     = rdata_q;
  assign TUNING_WORD_O  = tune_q;
  assign PHASE_O        = pacc_q;
  assign STEP_O         = step;
  assign CHIRP_ACTIVE_O = chirp;
endmodule : fcs_device

`default_nettype wire

// [design/fcs_host.sv]
`include "fcs_params.svh"
`default_nettype none

module fcs_host
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  // command port
  input  wire logic [4:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [7:0]       RDATA_O,
  // link to the device
  fcs_link_if.host         LINK
);
  fcs_byte_type            shadow_q [0:`FCS_H_ITEMS-1];
  fcs_host_state_type      state_q;
  logic [4:0]              idx_q;
  logic                    freeze_q;
  fcs_byte_type            rdata_q;
  logic                    go;
  logic                    fwd;

  // device address of each shadow byte, control sent last before the update
  function automatic logic [5:0] dev_addr(input logic [4:0] i);
    logic [5:0] a;
    a = {1'b0, i};
    if (i < 5'd6) begin
      dev_addr = `FCS_OFS_START + a;
    end else if (i < 5'd12) begin
      dev_addr = `FCS_OFS_STEP + a - 6'd6;
    end else if (i < 5'd15) begin
      dev_addr = `FCS_OFS_IVAL + a - 6'd12;
    end else if (i == 5'd15) begin
      dev_addr = `FCS_OFS_MODE;
    end else if (i < 5'd20) begin
      dev_addr = `FCS_OFS_TIMER + a - 6'd16;
    end else begin
      dev_addr = `FCS_OFS_CTRL;
    end
  endfunction : dev_addr

  assign go = WR_I && (ADDR_I == `FCS_H_OFS_CMD) && WDATA_I[`FCS_H_CMD_GO] && (state_q == FCS_H_IDLE);

  // reads of 1A..1F pass through to the accumulator readback, only while idle so wr and rd never meet
  assign fwd = RD_I && (ADDR_I >= 5'h1A) && (state_q == FCS_H_IDLE);

  // shadow bytes and freeze level from the command port
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < `FCS_H_ITEMS; i++) begin
        shadow_q[i] <= `FCS_RST_BYTE;
      end
      freeze_q <= 1'b0;
    end else if (WR_I) begin
      if (ADDR_I < 5'(`FCS_H_ITEMS)) begin
        shadow_q[ADDR_I] <= WDATA_I;
      end else if (ADDR_I == `FCS_H_OFS_CMD) begin
        freeze_q <= WDATA_I[`FCS_H_CMD_FREEZE];
      end
    end
  end

  // write every setting, then one update strobe to commit them
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= FCS_H_IDLE;
      idx_q   <= '0;
    end else begin
      unique case (state_q)
        FCS_H_IDLE: begin
          idx_q <= '0;
          if (go) begin
            state_q <= FCS_H_SEND;
          end
        end
        FCS_H_SEND: begin
          if (idx_q == 5'(`FCS_H_ITEMS - 1)) begin
            state_q <= FCS_H_COMMIT;
          end else begin
            idx_q <= idx_q + 1'b1;
          end
        end
        FCS_H_COMMIT: begin
          state_q <= FCS_H_IDLE;
        end
      endcase
    end
  end

  // status and shadow readback, one cycle after the strobe
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_q <= 8'h00;
    end else if (RD_I && ADDR_I < 5'(`FCS_H_ITEMS)) begin
      rdata_q <= shadow_q[ADDR_I];
    end else if (RD_I && ADDR_I == `FCS_H_OFS_STAT) begin
      rdata_q <= {6'h00, freeze_q, state_q != FCS_H_IDLE};
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign LINK.addr   = fwd ? (`FCS_OFS_ACC_RD + {1'b0, ADDR_I - 5'h1A}) : dev_addr(idx_q);
  assign LINK.wdata  = shadow_q[idx_q];
  assign LINK.wr     = (state_q == FCS_H_SEND);
  assign LINK.rd     = fwd;
  assign LINK.update = (state_q == FCS_H_COMMIT);
  assign LINK.freeze = freeze_q;
  // device answers one cycle after rd, the same cycle as local reads; the other side is zero then
  assign RDATA_O     = rdata_q | LINK.rdata;
endmodule : fcs_host

`default_nettype wire

// [bench/fcs_link_properties.sv]
`default_nettype none

module fcs_link_properties
  import fcs_pkg::*;
(
  // clock and reset
  input wire logic         SYS_CLK_I,
  input wire logic         RST_I,
  // link signals
  input wire logic [5:0]   addr,
  input wire logic [7:0]   wdata,
  input wire logic         wr,
  input wire logic         rd,
  input wire logic [7:0]   rdata,
  input wire logic         update,
  input wire logic         freeze,
  // device outputs
  input wire fcs_word_type TUNING_WORD_O,
  input wire fcs_word_type PHASE_O,
  input wire logic         STEP_O,
  input wire logic         CHIRP_ACTIVE_O
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  // auto-update pulses stay inside the device, so once armed the cause check stands down
  logic auto_armed_q;
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      auto_armed_q <= 1'b0;
    end else if (wr && addr == 6'h1F && wdata[0]) begin
      auto_armed_q <= 1'b1;
    end
  end

  // read data only in the cycle after a read strobe
  property p_rdata_idle; !$past(rd) |-> rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata set without read");
  // the update follows the last write, which is the control byte
  property p_commit; $fell(wr) |-> update && $past(addr) == 6'h1F; endproperty
  a_commit: assert property (p_commit) else $error("no update after writes");
  // update is a single-cycle strobe
  property p_upd_pulse; update |=> !update; endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update too long");
  // interval of at least one gives steps at least two cycles apart
  property p_step_gap; STEP_O |=> !STEP_O; endproperty
  a_step_gap: assert property (p_step_gap) else $error("steps back to back");
  // the counter runs only in chirp mode
  property p_chirp_only; !CHIRP_ACTIVE_O |-> !STEP_O; endproperty
  a_chirp_only: assert property (p_chirp_only) else $error("step outside chirp");
  // a held freeze pin stops the steps
  property p_freeze_stop; freeze && $past(freeze) && CHIRP_ACTIVE_O |-> !STEP_O; endproperty
  a_freeze_stop: assert property (p_freeze_stop) else $error("step during freeze");
  // frequency stays put during freeze unless an update landed lately
  property p_hold;
    freeze [*4] ##0 (!update && !$past(update) && !$past(update, 2) && !$past(update, 3))
      |-> $stable(TUNING_WORD_O);
  endproperty
  a_hold: assert property (p_hold) else $error("tuning moved during freeze");
  // phase accumulator integrates the tuning word
  property p_phase; PHASE_O != 48'h0 |-> PHASE_O == $past(PHASE_O) + $past(TUNING_WORD_O); endproperty
  a_phase: assert property (p_phase) else $error("phase not integrating");
  // tuning moves only after a step or an update
  property p_tune_cause;
    $changed(TUNING_WORD_O) && !auto_armed_q
      |-> $past(STEP_O, 2) || $past(update, 2) || $past(update, 3) || $past(update, 4);
  endproperty
  a_tune_cause: assert property (p_tune_cause) else $error("tuning moved without cause");

  // main scenarios
  c_step: cover property (STEP_O && CHIRP_ACTIVE_O);
  c_upd_frozen: cover property (freeze && update);
  c_resume: cover property ($fell(freeze) ##[1:20] STEP_O);
  c_auto: cover property (auto_armed_q && $changed(TUNING_WORD_O));
endmodule : fcs_link_properties

`default_nettype wire

// [bench/tb_fm_chirp_sweep_engine.sv]
`default_nettype none

module tb_fm_chirp_sweep_engine
  import fcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // clock, reset and command port
  logic         clk;
  logic         rst;
  logic [4:0]   addr_i;
  logic [7:0]   wdata_i;
  logic         wr_i;
  logic         rd_i;
  logic [7:0]   rdata_o;
  fcs_word_type tune;
  fcs_word_type phase;
  logic         step;
  logic         chirp;
  int           fails;
  int           num_checks;

  // both ends joined by one link
  fcs_link_if fcs_link_if_i ();
  fcs_device fcs_device_i (.SYS_CLK_I(clk), .RST_I(rst), .LINK(fcs_link_if_i.dev), .TUNING_WORD_O(tune),
    .PHASE_O(phase), .STEP_O(step), .CHIRP_ACTIVE_O(chirp));
  fcs_host fcs_host_i (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr_i), .WDATA_I(wdata_i), .WR_I(wr_i),
    .RD_I(rd_i), .RDATA_O(rdata_o), .LINK(fcs_link_if_i.host));
  fcs_link_properties fcs_link_properties_i (.SYS_CLK_I(clk), .RST_I(rst), .addr(fcs_link_if_i.addr),
    .wdata(fcs_link_if_i.wdata),
    .wr(fcs_link_if_i.wr), .rd(fcs_link_if_i.rd), .rdata(fcs_link_if_i.rdata),
    .update(fcs_link_if_i.update), .freeze(fcs_link_if_i.freeze), .TUNING_WORD_O(tune),
    .PHASE_O(phase), .STEP_O(step), .CHIRP_ACTIVE_O(chirp));

  // 20 MHz clock
  always #25 clk = ~clk;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write; a gap cycle keeps each strobe assigned once per step
  task automatic hw(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk);
    wr_i    <= 1'b0;
  endtask : hw

  // read data is taken in the cycle after the strobe
  task automatic hr(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : hr

  // shadow bytes go most significant first; timer left at zero
  task automatic prog(input fcs_word_type st, input fcs_word_type dl, input logic [19:0] iv,
                      input logic [2:0] md, input logic [7:0] ctl);
    for (int i = 0; i < 6; i++) hw(5'(i), st[47-8*i -: 8]);
    for (int i = 0; i < 6; i++) hw(5'(6 + i), dl[47-8*i -: 8]);
    for (int i = 0; i < 3; i++) hw(5'(12 + i), 8'({4'h0, iv} >> (16 - 8*i)));
    hw(5'h0F, {5'h00, md});
    hw(5'h14, ctl);
  endtask : prog

  // commit and wait for the host to go idle, bounded
  task automatic go(input logic frz);
    logic [7:0] s;
    int         n;
    hw(5'h18, {6'h00, frz, 1'b1});
    n = 0;
    do begin
      hr(5'h19, s);
      n++;
    end while (s[0] !== 1'b0 && n < 40);
    chk(48'(s[0]), 48'h0);
    chk(48'(s[1]), 48'(frz));
    repeat (4) @(posedge clk);
  endtask : go

  // restart under freeze, then one step and one full interval, done twice
  task automatic sweep(input fcs_word_type st, input fcs_word_type dl, input logic [19:0] iv);
    fcs_word_type t;
    int           n;
    logic [7:0]   d;
    fcs_word_type f;
    prog(st, dl, iv, 3'h3, 8'h04);
    repeat (2) begin
      go(1'b1);
      chk(tune, st);
      chk(48'(chirp), 48'h1);
      repeat (3 * iv + 3) @(negedge clk);
      chk(tune, st);
      hw(5'h18, 8'h00);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (step !== 1'b1 && n < 64);
      chk(48'(step), 48'h1);
      t = tune;
      n = 0;
      do begin
        @(negedge clk);
        n++;
        if (n == 2) chk(tune, t + dl);
      end while (step !== 1'b1 && n < 64);
      chk(48'(n), 48'(iv) + 48'h1);
      // freeze, then read the accumulator back most significant byte first
      hw(5'h18, 8'h02);
      f = '0;
      for (int i = 0; i < 6; i++) begin
        hr(5'(26 + i), d);
        f = {f[39:0], d};
      end
      chk(f, tune - st);
    end
  endtask : sweep

  initial begin
    logic [7:0]   d;
    logic [7:0]   rb;
    int unsigned  seed;
    fcs_word_type st;
    int           t0;
    int           t1;
    logic         prev;
    clk = 1'b0;
    rst = 1'b1;
    addr_i = 5'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    fails = 0;
    num_checks = 0;
    seed = $urandom(77);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // shadow readback, and a write to the read-only accumulator readback
    rb = 8'($urandom);
    hw(5'h03, rb);
    hr(5'h03, d);
    chk(48'(d), 48'(rb));
    hw(5'h1C, 8'hA5);
    hr(5'h1C, d);
    chk(48'(d), 48'h0);
    // up, down, wrap past full scale, zero step
    sweep(48'h0000_1000_0000, 48'h0000_0000_0100, 20'h00001);
    sweep(48'h0000_2000_0000, 48'hFFFF_FFFF_FF00, 20'h00003);
    sweep(48'hFFFF_FFFF_FFF0, 48'h0000_0000_0020, 20'h00002);
    sweep(48'h0000_3000_0000, 48'h0, 20'h00004);
    repeat (3) sweep(48'({$urandom, $urandom}), 48'({$urandom, $urandom}), 20'($urandom_range(7, 1)));
    // zero output, then reprogram while it holds
    prog(48'h0000_4000_0000, 48'h0000_0000_0010, 20'h00002, 3'h3, 8'h08);
    go(1'b0);
    repeat (10) @(negedge clk);
    chk(tune, 48'h0);
    chk(phase, 48'h0);
    st = 48'({$urandom, $urandom});
    sweep(st, 48'h0000_0000_0040, 20'h00002);
    // outside chirp the start word stands still
    prog(st, 48'h0000_0000_0040, 20'h00002, 3'h0, 8'h04);
    go(1'b0);
    chk(48'(chirp), 48'h0);
    repeat (12) @(negedge clk);
    chk(tune, st);
    // auto-update timer restarts the sweep every timer value plus one cycles
    prog(st, 48'h0000_0000_0100, 20'h00001, 3'h3, 8'h05);
    hw(5'h13, 8'h10);
    go(1'b0);
    t0 = -1;
    t1 = -1;
    prev = 1'b1;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk);
      if (tune === st && !prev && t0 < 0) t0 = i;
      else if (tune === st && !prev && t1 < 0) t1 = i;
      prev = (tune === st);
    end
    chk(48'(t1 - t0), 48'h11);
    complete_run();
  end
endmodule : tb_fm_chirp_sweep_engine

`default_nettype wire
